/* File: sbpc_pkg.sv */
// Purpose: Shared constants and types of the standby and block power control.
// Assumes: Byte-wide special function register bus with 20-bit addresses.
// Notes: All addresses, bit positions, key nibbles and reset values live here.
package sbpc_pkg;

  // ---------------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam logic [19:0] ADDR_STOP_UNLOCK_KEY = 20'h0f008;
  localparam logic [19:0] ADDR_STANDBY_MODE_CONTROL = 20'h0f009;
  localparam logic [19:0] ADDR_POWER_GATE_TIMERS = 20'h0f028;
  localparam logic [19:0] ADDR_POWER_GATE_TICK_PWM = 20'h0f029;
  localparam logic [19:0] ADDR_POWER_GATE_SERIAL = 20'h0f02a;
  localparam logic [19:0] ADDR_POWER_GATE_MELODY = 20'h0f02b;

  // ---------------------------------------------------------------------------
  // Field layout and values
  // ---------------------------------------------------------------------------
  localparam int HALT_REQUEST_BIT = 0;
  localparam int STOP_REQUEST_BIT = 1;
  localparam logic [3:0] KEY_FIRST_NIBBLE = 4'h5;
  localparam logic [3:0] KEY_SECOND_NIBBLE = 4'ha;
  localparam logic [7:0] GATE_RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_AS_ZERO = 8'h00;
  localparam logic [7:0] PERIPH_INIT_VALUE = 8'h00;

  localparam int TIMER_ZERO_OFF = 0;
  localparam int TICK_TIMER_OFF = 4;
  localparam int MODULATOR_ZERO_OFF = 0;
  localparam int TWO_WIRE_OFF = 7;
  localparam int ASYNC_SERIAL_OFF = 2;
  localparam int SYNC_SERIAL_OFF = 0;
  localparam int TONE_UNIT_OFF = 0;

  // ---------------------------------------------------------------------------
  // Peripheral numbering and widths
  // ---------------------------------------------------------------------------
  localparam int PER_TIMER0 = 0;
  localparam int PER_TICK = 4;
  localparam int PER_MOD0 = 5;
  localparam int PER_TWO_WIRE = 8;
  localparam int PER_ASYNC = 9;
  localparam int PER_SYNC = 10;
  localparam int PER_TONE = 11;
  localparam int PER_N = 12;
  localparam int IRQ_W = 32;
  localparam int P0_W = 8;
  localparam int SYNC_W = 3;
  localparam int CNT_W = 16;
  localparam int SETTLE_PULSES_DEFAULT = 8192;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_STOP = 2'b10,
    ST_WAKE = 2'b11
  } sbpc_state_t;

endpackage : sbpc_pkg

/* File: sbpc_key_if.sv */
// Purpose: Carries key writes and the armed flag between the mode logic and the acceptor.
// Assumes: All signals belong to the system clock domain.
// Notes: Consume is a one-cycle pulse on STOP entry.
`timescale 1ns/10ps
interface sbpc_key_if;
  logic wr;
  logic [7:0] data;
  logic pending;
  logic consume;
  logic armed;
  modport acceptor(input wr, input data, input pending, input consume, output armed);
  modport ctrl(output wr, output data, output pending, output consume, input armed);
endinterface : sbpc_key_if

/* File: sbpc_unlock.sv */
// Purpose: Two-write stop unlock acceptor.
// Assumes: Writes arrive as one-cycle strobes on the system clock.
// Notes: Only writes to the key register advance or break the sequence; STOP entry clears it and the armed flag.
`timescale 1ns/10ps
module sbpc_unlock
  import sbpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Key traffic
  sbpc_key_if.acceptor key
);

  typedef struct packed {
    logic first;
    logic armed;
  } sbpc_key_state_t;

  sbpc_key_state_t r;
  sbpc_key_state_t next_r;

  always_comb begin
    next_r = r;
    if (ce_i) begin
      if (key.consume) begin
        next_r.armed = 1'b0;
        next_r.first = 1'b0;
      end else if (key.wr) begin
        if (key.data[7:4] == KEY_FIRST_NIBBLE) begin
          next_r.first = 1'b1;
        end else if (r.first && key.data[7:4] == KEY_SECOND_NIBBLE) begin
          next_r.first = 1'b0;
          next_r.armed = r.armed | ~key.pending;
        end else begin
          next_r.first = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign key.armed = r.armed;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_second_key;
    ce_i && !key.consume && key.wr && r.first && key.data[7:4] == KEY_SECOND_NIBBLE;
  endsequence

  a_arm_on_second: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_second_key ##0 !key.pending |=> key.armed)
    else $error("Unlock did not arm after the second key.");

  a_arm_refused: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    key.pending && !key.armed |=> !key.armed)
    else $error("Unlock armed while an enabled interrupt was pending.");

  a_stray_breaks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && !key.consume && key.wr && r.first && key.data[7:4] != KEY_FIRST_NIBBLE
    && key.data[7:4] != KEY_SECOND_NIBBLE |=> !r.first && key.armed == $past(key.armed))
    else $error("A stray key write did not discard the first key.");

endmodule : sbpc_unlock

/* File: sbpc_gate.sv */
// Purpose: Power gate for one peripheral: reset, clock stop and register isolation.
// Assumes: The peripheral presents one register read path and one write strobe.
// Notes: Purely combinational; the disable bit comes from a registered control.
`timescale 1ns/10ps
module sbpc_gate
  import sbpc_pkg::*;
#(
  parameter logic [7:0] INIT = PERIPH_INIT_VALUE
) (
  // Control
  input wire logic off_i,
  input wire logic hold_i,
  // Peripheral register path
  input wire logic per_wr_i,
  input wire logic [7:0] per_rdata_i,
  output logic per_wr_o,
  output logic [7:0] per_rdata_o,
  // Peripheral reset and clock
  output logic per_rst_o,
  output logic per_clk_en_o
);

  assign per_rst_o = off_i;
  assign per_clk_en_o = ~off_i & ~hold_i;
  assign per_wr_o = per_wr_i & ~off_i;
  assign per_rdata_o = off_i ? INIT : per_rdata_i;

endmodule : sbpc_gate

/* File: sbpc_ctrl.sv */
// Purpose: Standby mode control, stop unlock and peripheral power gating.
// Assumes: The CPU core issues one-cycle byte read and write strobes on the system clock.
// Notes: The low-speed clock and its oscillator-ready flag arrive from outside and are synchronised.
`timescale 1ns/10ps
module sbpc_ctrl
  import sbpc_pkg::*;
#(
  parameter int SETTLE_PULSES = SETTLE_PULSES_DEFAULT
) (
  // Clock, reset and enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Special function register bus
  input wire logic [ADDR_W-1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_sel_o,
  // Interrupt status
  input wire logic [IRQ_W-1:0] int_enable_i,
  input wire logic [IRQ_W-1:0] int_request_i,
  input wire logic [P0_W-1:0] p0_enable_i,
  input wire logic [P0_W-1:0] p0_request_i,
  input wire logic nmi_req_i,
  input wire logic wdt_req_i,
  input wire logic master_interrupt_enable_i,
  // Low-speed oscillator
  input wire logic low_speed_clock_i,
  input wire logic ls_osc_ready_i,
  // Mode outputs
  output logic cpu_stop_o,
  output logic osc_stop_o,
  output logic halt_mode_o,
  output logic stop_mode_o,
  output logic irq_take_o,
  // Peripheral gating
  input wire logic [PER_N-1:0] per_wr_i,
  input wire logic [PER_N-1:0][7:0] per_rdata_i,
  output logic [PER_N-1:0] per_wr_o,
  output logic [PER_N-1:0][7:0] per_rdata_o,
  output logic [PER_N-1:0] per_rst_o,
  output logic [PER_N-1:0] per_clk_en_o
);

  typedef struct packed {
    sbpc_state_t state;
    logic halt_bit;
    logic stop_bit;
    logic [7:0] gate_timers;
    logic [7:0] gate_tick_pwm;
    logic [7:0] gate_serial;
    logic [7:0] gate_melody;
    logic [7:0] rdata;
    logic [SYNC_W-1:0] ls_sync;
    logic ls_level;
    logic [SYNC_W-1:0] osc_sync;
    logic osc_level;
    logic [CNT_W-1:0] cnt;
    logic svc;
    logic irq_take;
  } sbpc_ctrl_state_t;

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_PULSES - 1);

  sbpc_ctrl_state_t r;
  sbpc_ctrl_state_t next_r;
  sbpc_key_if key();
  logic pending;
  logic p0_wake;
  logic mode_wr;
  logic stop_go;
  logic ls_rise;
  logic [PER_N-1:0] per_off;
  logic per_hold;

  // ---------------------------------------------------------------------------
  // Stop unlock acceptor
  // ---------------------------------------------------------------------------
  assign pending = |(int_enable_i & int_request_i);
  assign p0_wake = |(p0_enable_i & p0_request_i);
  assign mode_wr = sfr_wr_i && sfr_addr_i == ADDR_STANDBY_MODE_CONTROL;
  assign key.wr = sfr_wr_i && sfr_addr_i == ADDR_STOP_UNLOCK_KEY;
  assign key.data = sfr_wdata_i;
  assign key.pending = pending;
  assign key.consume = stop_go;

  sbpc_unlock u_unlock (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .key(key.acceptor)
  );

  // ---------------------------------------------------------------------------
  // Register access and mode sequencing
  // ---------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    stop_go = 1'b0;
    ls_rise = 1'b0;
    if (ce_i) begin
      // The interrupt pulse lasts one enabled cycle; a frozen cycle holds it.
      next_r.irq_take = 1'b0;
      // Low-speed clock and ready flag only count once the last two stages agree.
      next_r.ls_sync = {r.ls_sync[SYNC_W-2:0], low_speed_clock_i};
      next_r.osc_sync = {r.osc_sync[SYNC_W-2:0], ls_osc_ready_i};
      if (r.ls_sync[1] == r.ls_sync[2]) begin
        next_r.ls_level = r.ls_sync[2];
        ls_rise = r.ls_sync[2] & ~r.ls_level;
      end
      if (r.osc_sync[1] == r.osc_sync[2]) begin
        next_r.osc_level = r.osc_sync[2];
      end

      if (sfr_wr_i) begin
        if (sfr_addr_i == ADDR_POWER_GATE_TIMERS) begin
          next_r.gate_timers = sfr_wdata_i;
        end else if (sfr_addr_i == ADDR_POWER_GATE_TICK_PWM) begin
          next_r.gate_tick_pwm = sfr_wdata_i;
        end else if (sfr_addr_i == ADDR_POWER_GATE_SERIAL) begin
          next_r.gate_serial = sfr_wdata_i;
        end else if (sfr_addr_i == ADDR_POWER_GATE_MELODY) begin
          next_r.gate_melody = sfr_wdata_i;
        end
      end

      if (sfr_rd_i) begin
        if (sfr_addr_i == ADDR_STOP_UNLOCK_KEY) begin
          next_r.rdata = READ_AS_ZERO;
        end else if (sfr_addr_i == ADDR_POWER_GATE_TIMERS) begin
          next_r.rdata = r.gate_timers;
        end else if (sfr_addr_i == ADDR_POWER_GATE_TICK_PWM) begin
          next_r.rdata = r.gate_tick_pwm;
        end else if (sfr_addr_i == ADDR_POWER_GATE_SERIAL) begin
          next_r.rdata = r.gate_serial;
        end else if (sfr_addr_i == ADDR_POWER_GATE_MELODY) begin
          next_r.rdata = r.gate_melody;
        end else begin
          next_r.rdata = READ_AS_ZERO;
        end
      end

      case (r.state)
        ST_RUN: begin
          if (mode_wr && !pending) begin
            case ({sfr_wdata_i[STOP_REQUEST_BIT], sfr_wdata_i[HALT_REQUEST_BIT]})
              2'b01: begin
                next_r.state = ST_HALT;
                next_r.halt_bit = 1'b1;
              end
              2'b10: begin
                if (key.armed) begin
                  stop_go = 1'b1;
                  next_r.state = ST_STOP;
                  next_r.stop_bit = 1'b1;
                end
              end
              default: begin
                next_r.state = ST_RUN;
              end
            endcase
          end
        end
        ST_HALT: begin
          if (nmi_req_i || wdt_req_i || pending) begin
            next_r.state = ST_RUN;
            next_r.halt_bit = 1'b0;
            next_r.irq_take = nmi_req_i | wdt_req_i | master_interrupt_enable_i;
          end
        end
        ST_STOP: begin
          if (nmi_req_i || p0_wake) begin
            next_r.state = ST_WAKE;
            next_r.stop_bit = 1'b0;
            next_r.cnt = '0;
            next_r.svc = nmi_req_i | master_interrupt_enable_i;
          end
        end
        ST_WAKE: begin
          if (r.osc_level && ls_rise) begin
            if (r.cnt == SETTLE_LAST) begin
              next_r.state = ST_RUN;
              next_r.irq_take = r.svc;
            end else begin
              next_r.cnt = r.cnt + CNT_W'(1);
            end
          end
        end
        default: begin
          next_r.state = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs and peripheral gates
  // ---------------------------------------------------------------------------
  assign sfr_rdata_o = r.rdata;
  assign sfr_sel_o = sfr_addr_i == ADDR_STOP_UNLOCK_KEY || sfr_addr_i == ADDR_STANDBY_MODE_CONTROL
    || sfr_addr_i == ADDR_POWER_GATE_TIMERS || sfr_addr_i == ADDR_POWER_GATE_TICK_PWM
    || sfr_addr_i == ADDR_POWER_GATE_SERIAL || sfr_addr_i == ADDR_POWER_GATE_MELODY;
  assign cpu_stop_o = r.state != ST_RUN;
  assign osc_stop_o = r.state == ST_STOP;
  assign halt_mode_o = r.halt_bit;
  assign stop_mode_o = r.stop_bit;
  assign irq_take_o = r.irq_take;
  assign per_hold = r.state == ST_STOP || r.state == ST_WAKE;

  assign per_off[PER_TIMER0 +: 4] = r.gate_timers[TIMER_ZERO_OFF +: 4];
  assign per_off[PER_TICK] = r.gate_tick_pwm[TICK_TIMER_OFF];
  assign per_off[PER_MOD0 +: 3] = r.gate_tick_pwm[MODULATOR_ZERO_OFF +: 3];
  assign per_off[PER_TWO_WIRE] = r.gate_serial[TWO_WIRE_OFF];
  assign per_off[PER_ASYNC] = r.gate_serial[ASYNC_SERIAL_OFF];
  assign per_off[PER_SYNC] = r.gate_serial[SYNC_SERIAL_OFF];
  assign per_off[PER_TONE] = r.gate_melody[TONE_UNIT_OFF];

  for (genvar g = 0; g < PER_N; g++) begin : g_gate
    sbpc_gate #(
      .INIT(PERIPH_INIT_VALUE)
    ) u_gate (
      .off_i(per_off[g]),
      .hold_i(per_hold),
      .per_wr_i(per_wr_i[g]),
      .per_rdata_i(per_rdata_i[g]),
      .per_wr_o(per_wr_o[g]),
      .per_rdata_o(per_rdata_o[g]),
      .per_rst_o(per_rst_o[g]),
      .per_clk_en_o(per_clk_en_o[g])
    );
    a_gate_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      per_off[g] |-> per_rdata_o[g] == PERIPH_INIT_VALUE && !per_wr_o[g])
      else $error("Disabled peripheral path was not isolated.");
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_mode_write(logic [1:0] v);
    ce_i && mode_wr && r.state == ST_RUN && !pending
      && {sfr_wdata_i[STOP_REQUEST_BIT], sfr_wdata_i[HALT_REQUEST_BIT]} == v;
  endsequence

  a_key_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && sfr_rd_i && sfr_addr_i == ADDR_STOP_UNLOCK_KEY |=> sfr_rdata_o == READ_AS_ZERO)
    else $error("Unlock key read returned nonzero data.");

  a_stop_needs_arm: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_mode_write(2'b10) ##0 !key.armed |=> r.state == ST_RUN && !stop_mode_o)
    else $error("STOP entered without an armed unlock.");

  a_stop_disarms: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(stop_mode_o) |-> !key.armed && r.state == ST_STOP)
    else $error("Unlock still armed after STOP entry.");

  a_halt_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_mode_write(2'b01) |=> r.state == ST_HALT && halt_mode_o && cpu_stop_o)
    else $error("Halt request did not enter HALT.");

  a_halt_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && r.state == ST_HALT && (nmi_req_i || wdt_req_i || pending) |=> r.state == ST_RUN && !halt_mode_o)
    else $error("HALT did not end on a wake request.");

  a_stop_wake: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && r.state == ST_STOP && (nmi_req_i || p0_wake) |=> r.state == ST_WAKE && !stop_mode_o)
    else $error("STOP did not clear on a wake request.");

  a_pending_blocks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && mode_wr && pending && r.state == ST_RUN |=> r.state == ST_RUN)
    else $error("Low-power mode entered with an interrupt pending.");

  a_both_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_mode_write(2'b11) |=> r.state == ST_RUN && !halt_mode_o && !stop_mode_o)
    else $error("Prohibited mode combination was entered.");

  a_no_service: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && r.state == ST_HALT && pending && !nmi_req_i && !wdt_req_i && !master_interrupt_enable_i
    |=> !irq_take_o)
    else $error("Interrupt taken with master enable clear.");

  a_timer_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && sfr_wr_i && sfr_addr_i == ADDR_POWER_GATE_TIMERS
    |=> per_rst_o[PER_TIMER0 +: 4] == $past(sfr_wdata_i[TIMER_ZERO_OFF +: 4]))
    else $error("Timer gate bits did not reach the timer resets.");

  sequence s_wake_done;
    r.state == ST_WAKE ##1 r.state == ST_RUN;
  endsequence

  a_stop_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_mode_write(2'b10) ##0 key.armed |=> stop_mode_o && osc_stop_o && cpu_stop_o)
    else $error("Armed stop request did not enter STOP.");

  a_wake_waits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && r.state == ST_WAKE && !r.osc_level |=> r.state == ST_WAKE)
    else $error("STOP wake ended before the oscillator was ready.");

  a_wake_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_wake_done |-> $past(r.cnt) == SETTLE_LAST)
    else $error("STOP wake ended before the settle count was reached.");

  a_per_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    r.state == ST_STOP || r.state == ST_WAKE |-> per_clk_en_o == '0)
    else $error("Peripheral clock ran during STOP.");

  a_irq_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && irq_take_o |=> !irq_take_o)
    else $error("Interrupt start pulse lasted more than one cycle.");

endmodule : sbpc_ctrl

/* File: sbpc_partner.sv */
// Purpose: Far-side model of the low-speed oscillator and the peripheral read paths.
// Assumes: System clock period of 10 ns; the low-speed clock is far slower.
// Notes: The oscillator stands still while the block stops it and restarts after a delay.
`timescale 1ns/10ps
module sbpc_partner
  import sbpc_pkg::*;
(
  // Control from the block
  input wire logic osc_stop_i,
  // Oscillator
  output logic ls_clk_o,
  output logic ls_ready_o,
  // Peripheral read data
  output logic [PER_N-1:0][7:0] per_rdata_o
);
  initial begin
    ls_clk_o = 1'h0;
    ls_ready_o = 1'h1;
  end
  // Start-up delay before the oscillator reports ready again.
  always @(osc_stop_i) begin
    ls_ready_o = 1'h0;
    if (!osc_stop_i) begin
      #100;
      ls_ready_o = 1'h1;
    end
  end
  always #40 ls_clk_o = ls_ready_o ? ~ls_clk_o : 1'h0;
  always_comb begin
    for (int k = 0; k < PER_N; k++) begin
      per_rdata_o[k] = 8'h40 + 8'(k);
    end
  end
endmodule : sbpc_partner

/* File: standby_and_block_power_control_tb.sv */
// Purpose: Self-checking bench of the standby and block power control.
// Assumes: Inputs change at the falling clock edge; settle count shortened to 4.
// Notes: Each scenario is its own task.
`timescale 1ns/10ps
module standby_and_block_power_control_tb;
  import sbpc_pkg::*;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [ADDR_W-1:0] addr = '0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic sel;
  logic [IRQ_W-1:0] ien = '0;
  logic [IRQ_W-1:0] ireq = '0;
  logic [P0_W-1:0] p0en = '0;
  logic [P0_W-1:0] p0req = '0;
  logic nmi = 1'h0;
  logic wdt = 1'h0;
  logic master_interrupt_enable = 1'h0;
  logic ce = 1'h1;
  logic ls_clk, ls_rdy, cpu_stop, osc_stop, halt_m, stop_m, irq_take;
  logic [PER_N-1:0] pwr = '1;
  logic [PER_N-1:0] pwr_o, prst, pclk;
  logic [PER_N-1:0][7:0] prd, prd_o;
  int error_cnt = 0;
  int total_checks = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  sbpc_ctrl #(.SETTLE_PULSES(4)) i_sbpc_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_sel_o(sel),
    .int_enable_i(ien), .int_request_i(ireq), .p0_enable_i(p0en), .p0_request_i(p0req), .nmi_req_i(nmi),
    .wdt_req_i(wdt), .master_interrupt_enable_i(master_interrupt_enable), .low_speed_clock_i(ls_clk), .ls_osc_ready_i(ls_rdy),
    .cpu_stop_o(cpu_stop), .osc_stop_o(osc_stop), .halt_mode_o(halt_m), .stop_mode_o(stop_m),
    .irq_take_o(irq_take), .per_wr_i(pwr), .per_rdata_i(prd), .per_wr_o(pwr_o), .per_rdata_o(prd_o),
    .per_rst_o(prst), .per_clk_en_o(pclk));
  sbpc_partner i_sbpc_partner (.osc_stop_i(osc_stop), .ls_clk_o(ls_clk), .ls_ready_o(ls_rdy), .per_rdata_o(prd));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clk_sys_i);
    wr = 1'h0;
  endtask : wr_reg

  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    addr = a;
    rd = 1'h1;
    @(negedge clk_sys_i);
    rd = 1'h0;
    @(negedge clk_sys_i);
    chk("rdata", rdata, exp);
  endtask : rd_chk

  task automatic arm(input logic [7:0] k1, input logic [7:0] k2);
    wr_reg(ADDR_STOP_UNLOCK_KEY, k1);
    wr_reg(ADDR_STOP_UNLOCK_KEY, k2);
  endtask : arm

  task automatic wait_run(input logic exp_irq);
    int n;
    n = 0;
    while (cpu_stop !== 1'h0 && n < 300) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("cpu_stop", cpu_stop, 1'h0);
    chk("irq_take", irq_take, exp_irq);
  endtask : wait_run

  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    chk("per_rst", prst, 12'h000);
    chk("per_clk", pclk, 12'hfff);
    wr_reg(ADDR_STOP_UNLOCK_KEY, 8'h5f);
    rd_chk(ADDR_STOP_UNLOCK_KEY, 8'h00);
    chk("sel_key", sel, 1'h1);
    rd_chk(ADDR_STANDBY_MODE_CONTROL, 8'h00);
    rd_chk(ADDR_POWER_GATE_TIMERS, 8'h00);
    rd_chk(ADDR_POWER_GATE_MELODY, 8'h00);
    wr_reg(20'h0f030, 8'hff);
    rd_chk(20'h0f030, 8'h00);
    chk("sel_none", sel, 1'h0);
    ce = 1'h0;
    wr_reg(ADDR_POWER_GATE_MELODY, 8'h01);
    chk("frozen", prst[PER_TONE], 1'h0);
    ce = 1'h1;
  endtask : t_reset

  task automatic t_gates(input logic [7:0] v0, v1, v2, v3, input logic [11:0] off);
    wr_reg(ADDR_POWER_GATE_TIMERS, v0);
    wr_reg(ADDR_POWER_GATE_TICK_PWM, v1);
    wr_reg(ADDR_POWER_GATE_SERIAL, v2);
    wr_reg(ADDR_POWER_GATE_MELODY, v3);
    chk("per_rst", prst, off);
    chk("per_clk", pclk, 12'(~off));
    chk("per_wr", pwr_o, 12'(~off));
    chk("per_rd0", prd_o[0], off[0] ? 8'h00 : 8'h40);
    chk("per_rd11", prd_o[11], off[11] ? 8'h00 : 8'h4b);
    rd_chk(ADDR_POWER_GATE_TIMERS, v0);
    rd_chk(ADDR_POWER_GATE_TICK_PWM, v1);
    rd_chk(ADDR_POWER_GATE_SERIAL, v2);
    rd_chk(ADDR_POWER_GATE_MELODY, v3);
    rd_chk(ADDR_STOP_UNLOCK_KEY, 8'h00);
  endtask : t_gates

  task automatic t_halt;
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h01);
    chk("halt", {halt_m, cpu_stop, stop_m}, 3'h6);
    chk("per_clk", pclk, 12'hfff);
    wdt = 1'h1;
    @(negedge clk_sys_i);
    wdt = 1'h0;
    chk("halt_clr", halt_m, 1'h0);
    wait_run(1'h1);
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h01);
    ien[3] = 1'h1;
    ireq[3] = 1'h1;
    @(negedge clk_sys_i);
    chk("halt_clr", halt_m, 1'h0);
    wait_run(1'h0);
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h01);
    chk("halt_blk", halt_m, 1'h0);
    ireq[3] = 1'h0;
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h03);
    chk("both", {halt_m, stop_m, cpu_stop}, 3'h0);
    master_interrupt_enable = 1'h1;
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h01);
    ireq[3] = 1'h1;
    @(negedge clk_sys_i);
    wait_run(1'h1);
    ireq[3] = 1'h0;
    master_interrupt_enable = 1'h0;
  endtask : t_halt

  task automatic t_stop;
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h02);
    chk("stop_nokey", stop_m, 1'h0);
    wr_reg(ADDR_STOP_UNLOCK_KEY, 8'h5c);
    wr_reg(ADDR_POWER_GATE_TIMERS, 8'h00);
    wr_reg(ADDR_STOP_UNLOCK_KEY, 8'ha3);
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h02);
    chk("stop", {stop_m, osc_stop, cpu_stop, halt_m}, 4'he);
    p0en[2] = 1'h1;
    p0req[2] = 1'h1;
    @(negedge clk_sys_i);
    chk("stop_clr", {stop_m, osc_stop}, 2'h0);
    wait_run(1'h0);
    p0req[2] = 1'h0;
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h02);
    chk("rearm", stop_m, 1'h0);
    wr_reg(ADDR_STOP_UNLOCK_KEY, 8'h51);
    arm(8'h30, 8'ha0);
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h02);
    chk("broken", stop_m, 1'h0);
    ireq[3] = 1'h1;
    arm(8'h55, 8'haa);
    ireq[3] = 1'h0;
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h02);
    chk("pend", stop_m, 1'h0);
    arm(8'h50, 8'ha0);
    rst_n_i = 1'h0;
    @(negedge clk_sys_i);
    rst_n_i = 1'h1;
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h02);
    chk("rst", stop_m, 1'h0);
    arm(8'h5f, 8'haf);
    wr_reg(ADDR_STANDBY_MODE_CONTROL, 8'h02);
    chk("stop", stop_m, 1'h1);
    nmi = 1'h1;
    @(negedge clk_sys_i);
    nmi = 1'h0;
    chk("stop_clr", stop_m, 1'h0);
    wait_run(1'h1);
  endtask : t_stop

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'h1;
    t_reset();
    t_gates(8'h0a, 8'h14, 8'h81, 8'h00, 12'h59a);
    t_gates(8'hf5, 8'heb, 8'h7e, 8'h01, 12'ha65);
    t_gates(8'h00, 8'h00, 8'h00, 8'h00, 12'h000);
    t_halt();
    t_stop();
    finish_test();
  end

  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule : standby_and_block_power_control_tb
